// File: verilog/loop_chain_pkg.sv
// Constants, register map and carrier types of the loop signal chain
package loop_chain_pkg;
	localparam int CLK_HZ     = 50_000_000;
	localparam int F_MARK_HZ  = 1200;
	localparam int F_SPACE_HZ = 2200;
	localparam logic [31:0] INC_MARK  = 32'((64'(F_MARK_HZ) << 32) / 64'(CLK_HZ));
	localparam logic [31:0] INC_SPACE = 32'((64'(F_SPACE_HZ) << 32) / 64'(CLK_HZ));
	localparam logic [15:0] HALF_THR  =
		16'((CLK_HZ / (2 * F_MARK_HZ) + CLK_HZ / (2 * F_SPACE_HZ)) / 2);
	localparam logic [15:0] HALF_MAX  = 16'hFFFF;
	localparam int DISP_SEC     = 3;
	localparam int DISP_CYC_DEF = DISP_SEC * CLK_HZ;
	localparam int DAC_W        = 14;

	typedef logic signed [47:0] wide_t;
	// Percent scale: 15360 = 100 %, so 16 table points sit 1024 apart
	localparam wide_t PCT_FULL    = 48'sh3C00;
	localparam int    CHR_SH      = 10;
	// Current scale: 480 codes per mA
	localparam wide_t CUR_FAIL_LO = 48'sh06C0;
	localparam wide_t CUR_SAT_LO  = 48'sh0720;
	localparam wide_t CUR_ZERO    = 48'sh0780;
	localparam wide_t CUR_SAT_HI  = 48'sh2670;
	localparam wide_t CUR_FAIL_HI = 48'sh2760;
	localparam wide_t TRIM_K      = 48'sh0444;
	localparam int    TRIM_SH     = 23;
	localparam int    SPAN_SH     = 16;
	localparam int    PID_SH      = 8;
	localparam wide_t INTEG_LIM   = 48'sh0000_0010_0000;
	localparam logic [3:0] CALLENDAR_LAST = 4'hD;

	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_DRIFT  = 12'h004;
	localparam logic [11:0] REG_LOWER  = 12'h008;
	localparam logic [11:0] REG_SPANR  = 12'h00C;
	localparam logic [11:0] REG_KP     = 12'h010;
	localparam logic [11:0] REG_TRINV  = 12'h014;
	localparam logic [11:0] REG_TD     = 12'h018;
	localparam logic [11:0] REG_LIMIT  = 12'h01C;
	localparam logic [11:0] REG_SLEW   = 12'h020;
	localparam logic [11:0] REG_CONST  = 12'h024;
	localparam logic [11:0] REG_MANMV  = 12'h028;
	localparam logic [11:0] REG_TRIM   = 12'h02C;
	localparam logic [11:0] REG_TIME   = 12'h030;
	localparam logic [11:0] REG_SETPT  = 12'h034;
	localparam logic [11:0] REG_RAMP   = 12'h038;
	localparam logic [11:0] REG_STAT   = 12'h03C;
	localparam logic [11:0] REG_RECIPE = 12'h040;
	localparam logic [11:0] REG_CHAR   = 12'h080;
	localparam logic [11:0] REG_MVSTAT = 12'h0C0;
	localparam logic [5:0]  TBL_MASK   = 6'h3F;

	typedef enum logic [1:0] {SRC_PV, SRC_MV, SRC_CONST, SRC_RSVD} src_t;

	typedef struct packed {
		logic [3:0] damp_shift;
		logic [3:0] recipe_last;
		logic [2:0] unit;
		logic [1:0] disp_b;
		logic [1:0] disp_a;
		logic       two_disp;
		src_t       current_source_select;
		logic       manual;
		logic       pause;
		logic       setpoint_follow_enable;
		logic       recipe_program_enable;
		logic       direct_action;
		logic       callendar;
		logic       sensor_tc;
		logic       fail_high;
		logic       pid_mode;
		logic [4:0] rsvd;
	} ctrl_t;
	localparam ctrl_t CTRL_RST = 32'h0000_0000;

	typedef struct packed {
		logic signed [15:0] reading;
		logic signed [15:0] terminal;
	} sample_t;
endpackage

// File: verilog/loop_signal_processing_chain.sv
// Loop signal chain: filter, ranging, recipe, PID, limits, output, display, FSK modem
// Operation
// [R01] FSK modem: one is 1200 Hz, zero is 2200 Hz, symmetric around loop level.
// [R02] Loop current demand goes to the converter as a 14-bit code.
// [R03] Transmitter mode failure drives 3.6 mA or 21 mA per configured direction.
// [R04] Transmitter mode output saturates at 3.8 mA and 20.5 mA.
// [R05] Transmitter mode maps 0 % to 4 mA and 100 % to 20 mA.
// [R06] Input filter is first-order low-pass with adjustable damping.
// [R07] Stored drift correction is added to the filtered reading.
// [R08] In PID mode range bottom is 0 % and range top 100 %.
// [R09] Recipe time counter advances, stops when paused, accepts a preset.
// [R10] Recipe program ramps and holds setpoint; setpoint following enabled separately.
// [R11] Callendar equation limits the recipe point list to 14 points, else 16.
// [R12] Error is setpoint minus PV or PV minus setpoint by action setting.
// [R13] MV is gain times error, scaled integral and derivative of PV.
// [R14] Characterization interpolates output percent across 16 table points.
// [R15] Manual mode takes the entered MV; power-up mode from startup setting.
// [R16] MV clamped between floor and ceiling and slew-limited.
// [R17] Output from PV, MV or constant current per source select.
// [R18] Commanded current never leaves 3.6 mA to 21 mA.
// [R19] Separate trims at 4 mA and 20 mA points correct the current.
// [R20] Display alternates two indications with a selectable PV unit.
// [R21] Two indications swap every 3 seconds.
// [R22] Thermocouple reading gets terminal temperature added for cold junction.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module loop_signal_processing_chain #(
	parameter int DISP_CYC = loop_chain_pkg::DISP_CYC_DEF
) (
	input  wire logic                    clk_in,
	input  wire logic                    rst_in,
	input  wire logic                    psel_in,
	input  wire logic                    penable_in,
	input  wire logic                    pwrite_in,
	input  wire logic [11:0]             paddr_in,
	input  wire logic [31:0]             pwdata_in,
	output logic                         pready_out,
	output logic [31:0]                  prdata_out,
	output logic                         pslverr_out,
	input  wire logic                    sample_valid_in,
	input  wire loop_chain_pkg::sample_t sample_in,
	input  wire logic                    sensor_fail_in,
	input  wire logic                    startup_control_state_in,
	input  wire logic                    modem_tx_bit_in,
	input  wire logic                    modem_tx_en_in,
	input  wire logic                    fsk_rx_in,
	output logic [13:0]                  dac_code_out,
	output logic                         fsk_tx_out,
	output logic                         fsk_tx_en_out,
	output logic                         modem_rx_bit_out,
	output logic                         disp_sel_out,
	output logic [15:0]                  disp_value_out,
	output logic [2:0]                   disp_unit_out
);
	import loop_chain_pkg::*;

	function automatic wide_t clamp(input wide_t v, input wide_t lo, input wide_t hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register bus

	ctrl_t              ctrl_r;
	logic               init_r;
	logic signed [15:0] drift_r, lower_r, kp_r, trinv_r, td_r, slew_r, const_r;
	logic signed [15:0] manmv_r, spman_r, ramp_r, floor_r, ceil_r, t4_r, t20_r;
	logic signed [31:0] spanr_r;
	logic [15:0]        time_r;
	logic [31:0]        recipe_mem [16];
	logic signed [15:0] char_mem [16];
	logic               pready_r, pslverr_r;
	logic [31:0]        prdata_r, rdata;
	logic               rd_ok;
	logic signed [15:0] pv_r, sp_r, mv_r;
	logic [13:0]        dac_r;

	wire access = psel_in & penable_in;
	wire wr_en  = access & pwrite_in & pready_r;
	wire [11:0] tbl_a = paddr_in & ~{6'h00, TBL_MASK};
	wire [3:0]  tbl_i = paddr_in[5:2];
	wire in_rec  = (tbl_a == REG_RECIPE);
	wire in_chr  = (tbl_a == REG_CHAR);
	wire wr_time = wr_en & (paddr_in == REG_TIME);

	always_comb begin
		rd_ok = 1'b1;
		rdata = 32'h0000_0000;
		if (paddr_in == REG_CTRL) begin
			rdata = ctrl_r;
		end else if (paddr_in == REG_DRIFT) begin
			rdata = 32'(drift_r);
		end else if (paddr_in == REG_LOWER) begin
			rdata = 32'(lower_r);
		end else if (paddr_in == REG_SPANR) begin
			rdata = spanr_r;
		end else if (paddr_in == REG_KP) begin
			rdata = 32'(kp_r);
		end else if (paddr_in == REG_TRINV) begin
			rdata = 32'(trinv_r);
		end else if (paddr_in == REG_TD) begin
			rdata = 32'(td_r);
		end else if (paddr_in == REG_LIMIT) begin
			rdata = {ceil_r, floor_r};
		end else if (paddr_in == REG_SLEW) begin
			rdata = 32'(slew_r);
		end else if (paddr_in == REG_CONST) begin
			rdata = 32'(const_r);
		end else if (paddr_in == REG_MANMV) begin
			rdata = 32'(manmv_r);
		end else if (paddr_in == REG_TRIM) begin
			rdata = {t20_r, t4_r};
		end else if (paddr_in == REG_TIME) begin
			rdata = {16'h0000, time_r};
		end else if (paddr_in == REG_SETPT) begin
			rdata = {sp_r, spman_r};
		end else if (paddr_in == REG_RAMP) begin
			rdata = 32'(ramp_r);
		end else if (paddr_in == REG_STAT) begin
			rdata = {2'b00, dac_r, pv_r};
		end else if (paddr_in == REG_MVSTAT) begin
			rdata = {sp_r, mv_r};
		end else if (in_rec) begin
			rdata = recipe_mem[tbl_i];
		end else if (in_chr) begin
			rdata = 32'(char_mem[tbl_i]);
		end else begin
			rd_ok = 1'b0;
		end
	end

	// One wait state keeps every bus output a flop
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= access & ~pready_r;
			pslverr_r <= access & ~pready_r & ~rd_ok;
			prdata_r  <= (access & ~pready_r & ~pwrite_in) ? rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_r  <= CTRL_RST;
			init_r  <= 1'b0;
			drift_r <= 16'sh0000;
			lower_r <= 16'sh0000;
			spanr_r <= 32'sh0000_0000;
			kp_r    <= 16'sh0000;
			trinv_r <= 16'sh0000;
			td_r    <= 16'sh0000;
			floor_r <= 16'sh0000;
			ceil_r  <= 16'sh0000;
			slew_r  <= 16'sh0000;
			const_r <= 16'sh0000;
			manmv_r <= 16'sh0000;
			t4_r    <= 16'sh0000;
			t20_r   <= 16'sh0000;
			spman_r <= 16'sh0000;
			ramp_r  <= 16'sh0000;
		end else begin
			init_r <= 1'b1;
			if (!init_r) begin
				ctrl_r.manual <= startup_control_state_in; // R15
			end else if (wr_en & (paddr_in == REG_CTRL)) begin
				ctrl_r <= pwdata_in;
			end
			if (wr_en & (paddr_in == REG_DRIFT)) drift_r <= pwdata_in[15:0];
			if (wr_en & (paddr_in == REG_LOWER)) lower_r <= pwdata_in[15:0];
			if (wr_en & (paddr_in == REG_SPANR)) spanr_r <= pwdata_in;
			if (wr_en & (paddr_in == REG_KP)) kp_r <= pwdata_in[15:0];
			if (wr_en & (paddr_in == REG_TRINV)) trinv_r <= pwdata_in[15:0];
			if (wr_en & (paddr_in == REG_TD)) td_r <= pwdata_in[15:0];
			if (wr_en & (paddr_in == REG_LIMIT)) begin
				floor_r <= pwdata_in[15:0];
				ceil_r  <= pwdata_in[31:16];
			end
			if (wr_en & (paddr_in == REG_SLEW)) slew_r <= pwdata_in[15:0];
			if (wr_en & (paddr_in == REG_CONST)) const_r <= pwdata_in[15:0];
			if (wr_en & (paddr_in == REG_MANMV)) manmv_r <= pwdata_in[15:0];
			if (wr_en & (paddr_in == REG_TRIM)) begin
				t4_r  <= pwdata_in[15:0];
				t20_r <= pwdata_in[31:16];
			end
			if (wr_en & (paddr_in == REG_SETPT)) spman_r <= pwdata_in[15:0];
			if (wr_en & (paddr_in == REG_RAMP)) ramp_r <= pwdata_in[15:0];
		end
	end

	// Tables hold no reset; software loads them before enabling their use
	always_ff @(posedge clk_in) begin
		if (wr_en & in_rec) recipe_mem[tbl_i] <= pwdata_in;
		if (wr_en & in_chr) char_mem[tbl_i] <= pwdata_in[15:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Measurement path

	logic               [3:0] stg_r;
	logic signed [15:0] filt_r, term_r;
	logic signed [16:0] fdiff;
	wide_t              trimmed, temp_v, pv_calc;

	assign fdiff   = 17'(sample_in.reading) - 17'(filt_r);
	assign trimmed = wide_t'(filt_r) + wide_t'(drift_r); // R07
	assign temp_v  = ctrl_r.sensor_tc ? trimmed + wide_t'(term_r) : trimmed; // R22
	// Linear ranging; span reciprocal is loaded by software to avoid a divider
	assign pv_calc = ((temp_v - wide_t'(lower_r)) * wide_t'(spanr_r)) >>> SPAN_SH; // R05 R08

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stg_r  <= 4'h0;
			filt_r <= 16'sh0000;
			term_r <= 16'sh0000;
			pv_r   <= 16'sh0000;
		end else begin
			stg_r <= {stg_r[2:0], sample_valid_in};
			if (sample_valid_in) begin
				filt_r <= 16'(17'(filt_r) + (fdiff >>> ctrl_r.damp_shift)); // R06
				term_r <= sample_in.terminal;
			end
			if (stg_r[0]) pv_r <= 16'(clamp(pv_calc, -48'sh7FFF, 48'sh7FFF));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Recipe time and setpoint

	logic [3:0]  seg_r;
	logic        run_r;
	wire  [3:0]  last_pt = (ctrl_r.callendar && ctrl_r.recipe_last > CALLENDAR_LAST) ?
		CALLENDAR_LAST : ctrl_r.recipe_last; // R11
	wire         more    = seg_r < last_pt;
	wire  [31:0] nxt_pt  = recipe_mem[more ? seg_r + 4'h1 : seg_r];
	wire  [31:0] cur_pt  = recipe_mem[seg_r];
	wide_t       sp_tgt, sp_step;

	assign sp_tgt  = wide_t'($signed(nxt_pt[15:0]));
	assign sp_step = (sp_tgt > wide_t'(sp_r)) ?
		clamp(wide_t'(sp_r) + wide_t'(ramp_r), wide_t'(sp_r), sp_tgt) :
		clamp(wide_t'(sp_r) - wide_t'(ramp_r), sp_tgt, wide_t'(sp_r));

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			time_r <= 16'h0000;
			seg_r  <= 4'h0;
			run_r  <= 1'b0;
			sp_r   <= 16'sh0000;
		end else begin
			run_r <= ctrl_r.recipe_program_enable;
			if (wr_time) begin
				time_r <= pwdata_in[15:0]; // R09
				seg_r  <= 4'h0;
			end else if (stg_r[0] & run_r & ~ctrl_r.pause & (time_r != 16'hFFFF)) begin
				time_r <= time_r + 16'h0001; // R09
			end
			if (!run_r && ctrl_r.recipe_program_enable) begin
				seg_r <= 4'h0;
				sp_r  <= $signed(cur_pt[15:0]);
			end else if (stg_r[1]) begin
				if (run_r) begin
					sp_r <= 16'(sp_step); // R10
					if (more && time_r >= nxt_pt[31:16]) seg_r <= seg_r + 4'h1; // R10
				end else if (ctrl_r.setpoint_follow_enable && ctrl_r.manual) begin
					sp_r <= pv_r; // R10
				end else begin
					sp_r <= spman_r;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// PID, characterization, auto/manual and limits

	logic signed [15:0] pvp_r;
	wide_t integ_r, err, integ_nxt, u, mv_pid, x, c0, c1, mv_chr, mv_tgt, mv_lim;
	wire [3:0] cidx = x[13:10];

	assign err       = ctrl_r.direct_action ? wide_t'(pv_r) - wide_t'(sp_r) :
		wide_t'(sp_r) - wide_t'(pv_r); // R12
	assign integ_nxt = clamp(integ_r + ((err * wide_t'(trinv_r)) >>> PID_SH),
		-INTEG_LIM, INTEG_LIM);
	assign u         = err + integ_r +
		((wide_t'(td_r) * (wide_t'(pv_r) - wide_t'(pvp_r))) >>> PID_SH); // R13
	assign mv_pid    = clamp((wide_t'(kp_r) * u) >>> PID_SH, 48'sh0, PCT_FULL); // R13
	assign x         = clamp(mv_pid, 48'sh0, PCT_FULL - 48'sh1);
	assign c0        = wide_t'(char_mem[cidx]);
	assign c1        = wide_t'(char_mem[cidx + 4'h1]);
	assign mv_chr    = c0 + (((c1 - c0) * wide_t'(x[9:0])) >>> CHR_SH); // R14
	assign mv_tgt    = ctrl_r.manual ? wide_t'(manmv_r) : mv_chr; // R15
	assign mv_lim    = clamp(mv_tgt, wide_t'(floor_r), wide_t'(ceil_r)); // R16

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			integ_r <= 48'sh0;
			pvp_r   <= 16'sh0000;
			mv_r    <= 16'sh0000;
		end else if (stg_r[2]) begin
			pvp_r   <= pv_r;
			integ_r <= ctrl_r.manual ? 48'sh0 : integ_nxt;
			mv_r    <= 16'(clamp(mv_lim, wide_t'(mv_r) - wide_t'(slew_r),
				wide_t'(mv_r) + wide_t'(slew_r))); // R16
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output current and trim

	wide_t pct, cur_raw, cur_tx, cur_trim;

	assign pct      = (ctrl_r.current_source_select == SRC_MV) ? wide_t'(mv_r) :
		wide_t'(pv_r); // R17
	assign cur_raw  = (ctrl_r.current_source_select == SRC_CONST) ? wide_t'(const_r) :
		CUR_ZERO + (pct >>> 1); // R05
	assign cur_tx   = ctrl_r.pid_mode ? cur_raw :
		sensor_fail_in ? (ctrl_r.fail_high ? CUR_FAIL_HI : CUR_FAIL_LO) : // R03
		clamp(cur_raw, CUR_SAT_LO, CUR_SAT_HI); // R04
	assign cur_trim = cur_tx + wide_t'(t4_r) + (((cur_tx - CUR_ZERO) *
		(wide_t'(t20_r) - wide_t'(t4_r)) * TRIM_K) >>> TRIM_SH); // R19

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dac_r <= DAC_W'(CUR_FAIL_LO);
		end else if (stg_r[3]) begin
			dac_r <= DAC_W'(clamp(cur_trim, CUR_FAIL_LO, CUR_FAIL_HI)); // R02 R18
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Display alternation

	logic [31:0] disp_cnt_r;
	logic        phase_r;
	wire  [1:0]  dsel = phase_r ? ctrl_r.disp_b : ctrl_r.disp_a;
	wire  [15:0] dval = (dsel == 2'd0) ? pv_r : (dsel == 2'd1) ? sp_r :
		(dsel == 2'd2) ? mv_r : {2'b00, dac_r};

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			disp_cnt_r <= 32'h0000_0000;
			phase_r    <= 1'b0;
		end else if (disp_cnt_r >= 32'(DISP_CYC - 1)) begin
			disp_cnt_r <= 32'h0000_0000;
			phase_r    <= ctrl_r.two_disp & ~phase_r; // R20 R21
		end else begin
			disp_cnt_r <= disp_cnt_r + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// FSK modem

	logic [31:0] nco_r;
	logic [15:0] half_r;
	logic        rx_d_r, rx_bit_r, tx_en_r;

	// Square tone; the external shaper keeps it DC-free on the loop
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			nco_r    <= 32'h0000_0000;
			tx_en_r  <= 1'b0;
			half_r   <= 16'h0000;
			rx_d_r   <= 1'b0;
			rx_bit_r <= 1'b1;
		end else begin
			tx_en_r <= modem_tx_en_in;
			nco_r   <= modem_tx_en_in ?
				nco_r + (modem_tx_bit_in ? INC_MARK : INC_SPACE) : 32'h0000_0000; // R01
			rx_d_r  <= fsk_rx_in;
			if (rx_d_r != fsk_rx_in) begin
				half_r   <= 16'h0000;
				rx_bit_r <= half_r > HALF_THR; // R01
			end else if (half_r != HALF_MAX) begin
				half_r <= half_r + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output flops

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			disp_sel_out   <= 1'b0;
			disp_value_out <= 16'h0000;
			disp_unit_out  <= 3'h0;
		end else begin
			disp_sel_out   <= phase_r;
			disp_value_out <= dval;
			disp_unit_out  <= ctrl_r.unit; // R20
		end
	end

	assign pready_out       = pready_r;
	assign prdata_out       = prdata_r;
	assign pslverr_out      = pslverr_r;
	assign dac_code_out     = dac_r;
	assign fsk_tx_out       = nco_r[31];
	assign fsk_tx_en_out    = tx_en_r;
	assign modem_rx_bit_out = rx_bit_r;
endmodule // loop_signal_processing_chain

// File: bench/loop_chain_monitor.sv
// Concurrent checks on the ports of the loop signal chain
`timescale 1ns/10ps
module loop_chain_monitor (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pready_out,
	input wire logic [31:0] prdata_out,
	input wire logic        pslverr_out,
	input wire logic        sample_valid_in,
	input wire logic        modem_tx_en_in,
	input wire logic [13:0] dac_code_out,
	input wire logic        fsk_tx_out,
	input wire logic        fsk_tx_en_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_access;
		psel_in && penable_in;
	endsequence
	// One wait state, never more
	chk_apb_answer: assert property (s_setup ##1 s_access |=> pready_out)
		else $error("no answer one cycle into access");
	chk_ready_access: assert property (pready_out |-> s_access and $past(psel_in && penable_in))
		else $error("ready outside access phase");
	chk_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	chk_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	chk_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
		else $error("read data outside answer");
	chk_dac_span: assert property (dac_code_out >= 14'h06C0 && dac_code_out <= 14'h2760)
		else $error("loop code out of span");
	// Code moves only at the end of the sample pipeline
	chk_dac_cause: assert property ($changed(dac_code_out) |-> $past(sample_valid_in, 5))
		else $error("loop code moved without sample");
	chk_tx_en_copy: assert property (fsk_tx_en_out == $past(modem_tx_en_in))
		else $error("tone enable not copied");
	chk_tx_silent: assert property (!modem_tx_en_in [*2] |=> !fsk_tx_out)
		else $error("tone while disabled");
endmodule // loop_chain_monitor

bind loop_signal_processing_chain loop_chain_monitor mon (.clk_in, .rst_in, .psel_in,
	.penable_in, .pready_out, .prdata_out, .pslverr_out, .sample_valid_in, .modem_tx_en_in,
	.dac_code_out, .fsk_tx_out, .fsk_tx_en_out);

// File: bench/hart_host_model.sv
// Loop host model: sends a keyed tone and times the device's tone
`timescale 1ns/10ps
module hart_host_model (
	input  wire logic clk_in,
	input  wire logic send_in,
	input  wire logic bit_in,
	input  wire logic tone_in,
	output logic      tone_out,
	output int        half_out
);
	import loop_chain_pkg::*;
	int   cnt  = 0;
	int   meas = 0;
	logic last = 1'b0;
	initial tone_out = 1'b0;
	initial half_out = 0;
	// Even duty square, so the loop mean level stays put
	always @(posedge clk_in) begin
		if (send_in && cnt >= CLK_HZ / (2 * (bit_in ? F_MARK_HZ : F_SPACE_HZ)) - 1) begin
			tone_out <= ~tone_out;
			cnt      <= 0;
		end else begin
			cnt <= send_in ? cnt + 1 : 0;
		end
	end
	// Edge to edge count of the device's tone
	always @(posedge clk_in) begin
		last <= tone_in;
		meas <= (tone_in != last) ? 1 : meas + 1;
		if (tone_in != last)
			half_out <= meas;
	end
endmodule // hart_host_model

// File: bench/tb_loop_signal_processing_chain.sv
// Self-checking bench for the loop signal chain
`timescale 1ns/10ps
module tb_loop_signal_processing_chain;
	import loop_chain_pkg::*;
	logic        clk_in = '0, rst_in = 1'b1, psel_in = '0, penable_in = '0, pwrite_in = '0;
	logic [11:0] paddr_in = '0;
	logic [31:0] pwdata_in = '0, prdata_out, rd;
	logic        pready_out, pslverr_out, err, sample_valid_in = '0, sensor_fail_in = '0;
	logic        startup_control_state_in = 1'b1, modem_tx_bit_in = '0, modem_tx_en_in = '0;
	logic        fsk_rx_in, fsk_tx_out, fsk_tx_en_out, modem_rx_bit_out, disp_sel_out, v;
	logic        send = '0;
	logic [13:0] dac_code_out;
	logic [15:0] disp_value_out;
	logic [2:0]  disp_unit_out;
	sample_t     sample_in = '0;
	int          fail_count = 0, check_count = 0, cycles = 0, half, n;

	loop_signal_processing_chain #(.DISP_CYC(16)) dut (.clk_in, .rst_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out,
		.pslverr_out, .sample_valid_in, .sample_in, .sensor_fail_in,
		.startup_control_state_in, .modem_tx_bit_in, .modem_tx_en_in, .fsk_rx_in,
		.dac_code_out, .fsk_tx_out, .fsk_tx_en_out, .modem_rx_bit_out, .disp_sel_out,
		.disp_value_out, .disp_unit_out);
	hart_host_model host (.clk_in, .send_in(send), .bit_in(modem_tx_bit_in),
		.tone_in(fsk_tx_out), .tone_out(fsk_rx_in), .half_out(half));

	////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task conclude;
		if (fail_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic feed(input logic [15:0] r, t, input logic [13:0] exp);
		@(posedge clk_in);
		sample_valid_in <= 1'b1;
		sample_in       <= {r, t};
		@(posedge clk_in);
		sample_valid_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		check("loop code", dac_code_out, exp);
	endtask
	// Tone edges jitter by a cycle or two
	function automatic logic near(input int h, input int f);
		return (h - CLK_HZ / (2 * f)) inside {[-2:2]};
	endfunction

	////////////////////////////////////////////////////////////////////
	always #10 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			fail_count++;
			conclude();
		end
	end
	initial begin
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		fork
			begin
				modem_tx_en_in <= 1'b1;
				send           <= 1'b1;
				repeat (34500) @(posedge clk_in);
				check("rx bit", modem_rx_bit_out, 32'h0);
				check("tx half", near(half, F_SPACE_HZ), 32'h1);
				modem_tx_bit_in <= 1'b1;
				repeat (42500) @(posedge clk_in);
				check("rx bit", modem_rx_bit_out, 32'h1);
				check("tx half", near(half, F_MARK_HZ), 32'h1);
			end
			begin
				apb(1'b0, REG_CTRL, '0);
				check("ctrl", rd, 32'h0000_2000);
				apb(1'b0, 12'hFFC, '0);
				check("slverr", err, 32'h1);
				// Straight-line table keeps the controller path free of unknowns
				for (int i = 0; i < 16; i++) begin
					apb(1'b1, REG_CHAR + 12'(4 * i), 32'(1024 * i));
				end
				apb(1'b1, REG_LOWER, '0);
				apb(1'b1, REG_SPANR, 32'h0000_8000);
				apb(1'b1, REG_TRIM, '0);
				apb(1'b1, REG_DRIFT, '0);
				apb(1'b1, REG_CTRL, 32'h1000_0000);
				feed(16'h0000, '0, 14'h0780);
				feed(16'h07D0, '0, 14'h087A);
				feed(16'h07D0, '0, 14'h08F7);
				apb(1'b1, REG_CTRL, '0);
				feed(16'h0000, '0, 14'h0780);
				feed(16'h7800, '0, 14'h2580);
				feed(16'h7FFF, '0, 14'h2670);
				feed(16'hF830, '0, 14'h0720);
				apb(1'b1, REG_DRIFT, 32'h0000_00C8);
				feed(16'h0000, '0, 14'h07B2);
				apb(1'b1, REG_DRIFT, '0);
				apb(1'b1, REG_CTRL, 32'h0000_0080);
				feed(16'h0000, 16'h0190, 14'h07E4);
				apb(1'b1, REG_CTRL, '0);
				sensor_fail_in <= 1'b1;
				feed(16'h0000, '0, 14'h06C0);
				apb(1'b1, REG_CTRL, 32'h0000_0040);
				feed(16'h0000, '0, 14'h2760);
				sensor_fail_in <= 1'b0;
				apb(1'b1, REG_TRIM, 32'h0030_0030);
				feed(16'h0000, '0, 14'h07B0);
				apb(1'b1, REG_TRIM, '0);
				apb(1'b1, REG_CTRL, 32'h0000_8020);
				apb(1'b1, REG_CONST, 32'h0000_1388);
				feed(16'h0000, '0, 14'h1388);
				apb(1'b1, REG_CONST, 32'h0000_2EE0);
				feed(16'h0000, '0, 14'h2760);
				apb(1'b1, REG_LIMIT, 32'h2000_0100);
				apb(1'b1, REG_SLEW, 32'h0000_3C00);
				apb(1'b1, REG_KP, 32'h0000_0100);
				apb(1'b1, REG_SETPT, 32'h0000_1200);
				apb(1'b1, REG_CTRL, 32'h0000_4020);
				feed(16'h0000, '0, 14'h1080);
				apb(1'b1, REG_CTRL, 32'h0000_4220);
				feed(16'h0000, '0, 14'h0800);
				apb(1'b1, REG_MANMV, 32'h0000_3000);
				apb(1'b1, REG_CTRL, 32'h0000_6020);
				feed(16'h0000, '0, 14'h1780);
				apb(1'b1, REG_SLEW, 32'h0000_0800);
				apb(1'b1, REG_MANMV, '0);
				feed(16'h0000, '0, 14'h1380);
				apb(1'b0, REG_MVSTAT, '0);
				check("mv status", rd, 32'h1200_1800);
				apb(1'b1, REG_CTRL, 32'h00B9_0000);
				v = disp_sel_out;
				do @(posedge clk_in); while (disp_sel_out === v);
				v = disp_sel_out;
				n = 0;
				do begin
					@(posedge clk_in);
					n++;
				end while (disp_sel_out === v);
				check("swap period", n, 32'h10);
				check("unit", disp_unit_out, 32'h5);
				check("disp value", disp_value_out, disp_sel_out ? 32'h0000_1380 : 32'h0);
			end
		join
		conclude();
	end
endmodule // tb_loop_signal_processing_chain
